// file: rtl/cep_pkg.sv
// Constants and types shared by the exception priority unit.
`default_nettype none
package cep_pkg;
  // ==========================================================
  // Vector addresses and offsets
  localparam logic [63:0] RESET_VEC = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [63:0] BASE_BEV0 = 64'hFFFF_FFFF_8000_0000;
  localparam logic [63:0] BASE_BEV1 = 64'hFFFF_FFFF_BFC0_0200;
  localparam logic [63:0] CERR_BASE_BEV0 = 64'hFFFF_FFFF_A000_0000;
  localparam logic [63:0] OFF_REFILL = 64'h0000_0000_0000_0000;
  localparam logic [63:0] OFF_XREFILL = 64'h0000_0000_0000_0080;
  localparam logic [63:0] OFF_CERR = 64'h0000_0000_0000_0100;
  localparam logic [63:0] OFF_GEN = 64'h0000_0000_0000_0180;
  // ==========================================================
  // Reset values of the replacement pointer, locked count, mode field
  localparam logic [5:0] RANDOM_TOP = 6'h2F;
  localparam logic [5:0] WIRED_RST = 6'h00;
  localparam logic EM_RST = 1'h0;
  // Identity code; the value is arbitrary.
  localparam logic [7:0] IDENT_CODE = 8'h3C;
  // Interrupt register bit that raises the nonmaskable interrupt.
  localparam int NMI_INT_BIT = 6;
  // ==========================================================
  // Cause codes, customary architecture values
  localparam logic [4:0] CC_INT = 5'h00;
  localparam logic [4:0] CC_MOD = 5'h01;
  localparam logic [4:0] CC_XLAT_MISS_LOAD_CODE = 5'h02;
  localparam logic [4:0] CC_XLAT_MISS_STORE_CODE = 5'h03;
  localparam logic [4:0] CC_ADDR_FAULT_LOAD_CODE = 5'h04;
  localparam logic [4:0] CC_ADDR_FAULT_STORE_CODE = 5'h05;
  localparam logic [4:0] CC_IBE = 5'h06;
  localparam logic [4:0] CC_DBE = 5'h07;
  localparam logic [4:0] CC_BP = 5'h09;
  localparam logic [4:0] CC_WATCH = 5'h17;
  // ==========================================================
  // Priority ranks, zero is the highest general rank
  localparam int NUM_RANK = 15;
  localparam logic [3:0] RK_F_DBG = 4'h0;
  localparam logic [3:0] RK_F_ADE = 4'h1;
  localparam logic [3:0] RK_F_REFILL = 4'h2;
  localparam logic [3:0] RK_F_INVAL = 4'h3;
  localparam logic [3:0] RK_F_CERR = 4'h4;
  localparam logic [3:0] RK_F_BUS = 4'h5;
  localparam logic [3:0] RK_EXEC = 4'h6;
  localparam logic [3:0] RK_D_ADE = 4'h7;
  localparam logic [3:0] RK_D_REFILL = 4'h8;
  localparam logic [3:0] RK_D_INVAL = 4'h9;
  localparam logic [3:0] RK_D_MOD = 4'hA;
  localparam logic [3:0] RK_D_CERR = 4'hB;
  localparam logic [3:0] RK_D_BUS = 4'hC;
  localparam logic [3:0] RK_WATCH = 4'hD;
  localparam logic [3:0] RK_INT = 4'hE;
  // ==========================================================
  // Access size and privilege encodings, address field positions
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_DWORD = 2'h3;
  localparam logic [1:0] MODE_SUP = 2'h1;
  localparam logic [1:0] MODE_USER = 2'h2;
  localparam int VPN2_LSB = 13;
  localparam int XCTX_MSB = 39;
  localparam logic [34:0] SSEG_TOP = 35'h7_FFFF_FFFE;
  localparam logic [33:0] KSEG01_TOP = 34'h3_FFFF_FFFE;
  localparam logic [1:0] XSSEG_TOP = 2'h1;
  localparam logic [1:0] XKPHYS_TOP = 2'h2;
  // ==========================================================
  // Kind of entry taken in a cycle
  typedef enum logic [2:0] {
    ENT_NONE, ENT_COLD, ENT_SOFT, ENT_NMI, ENT_GEN, ENT_CERR
  } cep_entry_t;
endpackage
`default_nettype wire

// file: rtl/cep_exc_unit.sv
// Exception recognition, ranking and entry state of the core.
`default_nettype none
// Functional notes
// - Report only the highest ranked of simultaneous exceptions.
// - Interrupt and NMI ranked in the cycle the logic samples them.
// - Cold reset taken when its input is asserted and then released.
// - Cold reset, soft reset and NMI fetch from the fixed reset vector.
// - Cold reset clears restart, shutdown bits; sets error level, boot.
// - Cold reset sets replacement pointer to 47; soft reset, NMI keep it.
// - Cold reset clears locked entry count; soft reset and NMI keep it.
// - Cold reset clears mode enable; clock ratio, endian stay hardwired.
// - Soft reset and NMI write restart address to error return register.
// - Soft reset starts at reset vector on release; cannot be masked.
// - Soft reset, NMI set error level, boot and restart flag; keep rest.
// - Soft reset resets cache and bus machines; NMI does not.
// - NMI raised on falling NMI input or write of interrupt bit 6.
// - NMI taken regardless of exception level, error level, enable.
// - NMI taken only at an instruction boundary, memory state kept.
// - Address error on misalignment or privileged space reference.
// - Address error uses common vector, load/store code, keeps address.
// - Return address is faulting instruction, or branch with delay flag.
// - Refill raised when a mapped reference finds no matching entry.
// - Invalid on match with clear valid; modified on clean store match.
// - Refill uses 32 or 64 bit vector per space, only when level clear.
// - Refill sets load/store code, captures address into fault registers.
// - Exception address is base plus 0x000, 0x080, 0x100 or 0x180.
// - Vector base chosen by the boot vector bit.
// - Any general exception other than a cache error sets the exception level bit.
module cep_exc_unit import cep_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // External reset and interrupt pins
  input wire logic power_on_reset_n,
  input wire logic soft_reset_n,
  input wire logic nmi_n,
  input wire logic int_reg_wr,
  input wire logic [7:0] int_reg_wdata,
  input wire logic irq_pending,
  // Pipeline state
  input wire logic insn_boundary,
  input wire logic [63:0] insn_pc,
  input wire logic in_delay_slot,
  input wire logic [63:0] branch_pc,
  input wire logic [1:0] cur_mode,
  // Fetch access and its translation result
  input wire logic f_valid,
  input wire logic [63:0] f_vaddr,
  input wire logic f_tlb_hit,
  input wire logic f_tlb_valid,
  input wire logic f_dbg_break,
  input wire logic f_cache_err,
  input wire logic f_bus_err,
  // Execution group request
  input wire logic exec_req,
  input wire logic [4:0] exec_code,
  // Data access and its translation result
  input wire logic d_valid,
  input wire logic d_store,
  input wire logic [1:0] d_size,
  input wire logic [63:0] d_vaddr,
  input wire logic d_tlb_hit,
  input wire logic d_tlb_valid,
  input wire logic d_tlb_dirty,
  input wire logic d_cache_err,
  input wire logic d_bus_err,
  input wire logic watch_hit,
  input wire logic [7:0] address_space_id,
  // Status inputs and software writes
  input wire logic global_irq_enable,
  input wire logic user_wide_addressing,
  input wire logic supervisor_wide_addressing,
  input wire logic kernel_wide_addressing,
  input wire logic sw_status_wr,
  input wire logic sw_error_level,
  input wire logic sw_boot_vector,
  input wire logic sw_exception_level,
  input wire logic sw_wired_wr,
  input wire logic [5:0] sw_wired,
  input wire logic sw_mode_enable_wr,
  input wire logic sw_mode_enable,
  input wire logic [2:0] clock_ratio_hw,
  input wire logic endian_hw,
  // Entry outputs
  output logic exc_taken,
  output logic [63:0] exc_vector,
  output logic cache_bus_reset,
  // Status and configuration outputs
  output logic error_level_bit,
  output logic boot_vector_select,
  output logic soft_restart_flag,
  output logic tlb_shutdown_bit,
  output logic exception_level_bit,
  output logic mode_enable_field,
  output logic [2:0] clock_ratio_field,
  output logic endian_select,
  output logic [7:0] processor_identity_reg,
  output logic [5:0] tlb_random,
  output logic [5:0] tlb_wired,
  // Fault capture outputs
  output logic [4:0] cause_code_field,
  output logic delay_slot_flag,
  output logic [63:0] exception_return_addr,
  output logic [63:0] error_return_addr,
  output logic [63:0] faulting_vaddr_reg,
  output logic [63:0] tlb_entry_high,
  output logic [26:0] wide_page_table_pointer
);
  // ==========================================================
  // Helper functions

  // Misaligned or privileged reference; byte size never misaligns.
  function automatic logic addr_fault(input logic [63:0] va,
      input logic [1:0] sz, input logic [1:0] mode);
    logic mis;
    logic ksp;
    logic ssp;
    mis = ((sz == SZ_HALF) && va[0]) ||
          ((sz == SZ_WORD) && (va[1:0] != 2'h0)) ||
          ((sz == SZ_DWORD) && (va[2:0] != 3'h0));
    ssp = (va[63:62] == XSSEG_TOP) || (va[63:29] == SSEG_TOP);
    ksp = (va[63:40] != 24'h00_0000) && !ssp;
    return mis || (ksp && (mode != 2'h0)) ||
           (ssp && (mode == MODE_USER));
  endfunction

  // Kernel segments 0/1 and the physical window bypass translation.
  function automatic logic is_mapped(input logic [63:0] va);
    return (va[63:62] != XKPHYS_TOP) && (va[63:30] != KSEG01_TOP);
  endfunction

  // Wide refill chosen by the referenced space, not the current mode.
  function automatic logic wide_space(input logic [63:0] va,
      input logic ux, input logic sx, input logic kx);
    if (va[63:40] == 24'h00_0000) begin
      return ux;
    end else if (va[63:29] == SSEG_TOP) begin
      return kx;
    end else if (va[63:62] == XSSEG_TOP) begin
      return sx;
    end
    return kx;
  endfunction

  // Lowest set index wins, so index zero is the highest rank.
  function automatic logic [3:0] first_set(input logic [NUM_RANK-1:0] r);
    logic [3:0] idx;
    idx = RK_INT;
    for (int i = NUM_RANK - 1; i >= 0; i--) begin
      if (r[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ==========================================================
  // State registers
  logic por_low_r, srst_low_r, nmi_prev_r, nmi_pend_r;
  logic erl_r, bev_r, sr_r, ts_r, exl_r, em_r, bd_r, taken_r;
  logic cbreset_r, endian_r;
  logic [2:0] ec_r;
  logic [5:0] random_r, wired_r;
  logic [4:0] code_r;
  logic [63:0] vec_r, epc_r, err_epc_r, badv_r, ehi_r;
  logic [26:0] xctx_r;
  cep_entry_t ent;

  // ==========================================================
  // Event detection on the pins
  wire cold_evt = por_low_r && power_on_reset_n;
  wire soft_evt = srst_low_r && soft_reset_n && !cold_evt;
  wire hold = !power_on_reset_n || !soft_reset_n;
  wire nmi_set = (nmi_prev_r && !nmi_n) ||
                 (int_reg_wr && int_reg_wdata[NMI_INT_BIT]);
  // Masking bits are not consulted for NMI.
  wire nmi_take = nmi_pend_r && insn_boundary;

  // ==========================================================
  // Fault detection on the fetch and data accesses
  wire f_ade = f_valid && addr_fault(f_vaddr, SZ_WORD, cur_mode);
  wire d_ade = d_valid && addr_fault(d_vaddr, d_size, cur_mode);
  wire f_map = f_valid && !f_ade && is_mapped(f_vaddr);
  wire d_map = d_valid && !d_ade && is_mapped(d_vaddr);
  wire f_refill = f_map && !f_tlb_hit;
  wire d_refill = d_map && !d_tlb_hit;
  wire f_inval = f_map && f_tlb_hit && !f_tlb_valid;
  wire d_inval = d_map && d_tlb_hit && !d_tlb_valid;
  wire d_mod = d_map && d_store && d_tlb_hit && d_tlb_valid &&
               !d_tlb_dirty;
  // Interrupt sampled in the same cycle as NMI, ranked below it.
  wire int_req = irq_pending && global_irq_enable && !exl_r && !erl_r;

  // ==========================================================
  // Ranking of general exceptions
  wire [NUM_RANK-1:0] req = {int_req, watch_hit, d_valid && d_bus_err,
    d_valid && d_cache_err, d_mod, d_inval, d_refill, d_ade, exec_req,
    f_valid && f_bus_err, f_valid && f_cache_err, f_inval, f_refill,
    f_ade, f_valid && f_dbg_break};
  wire [3:0] rank = first_set(req);
  wire gen_any = insn_boundary && (req != '0);
  wire is_cerr = (rank == RK_F_CERR) || (rank == RK_D_CERR);

  // Resets outrank NMI, NMI outranks all general ones.
  always_comb begin
    if (cold_evt) begin
      ent = ENT_COLD;
    end else if (soft_evt) begin
      ent = ENT_SOFT;
    end else if (hold) begin
      ent = ENT_NONE;
    end else if (nmi_take) begin
      ent = ENT_NMI;
    end else if (gen_any) begin
      ent = is_cerr ? ENT_CERR : ENT_GEN;
    end else begin
      ent = ENT_NONE;
    end
  end

  // ==========================================================
  // Fault address, cause code and vector selection
  wire fetch_side = (rank <= RK_F_BUS);
  wire [63:0] fault_va = fetch_side ? f_vaddr : d_vaddr;
  wire store_side = !fetch_side && d_store;
  wire is_ade = (rank == RK_F_ADE) || (rank == RK_D_ADE);
  wire is_refill = (rank == RK_F_REFILL) || (rank == RK_D_REFILL);
  wire is_tlb = is_refill || (rank == RK_F_INVAL) ||
                (rank == RK_D_INVAL) || (rank == RK_D_MOD);
  wire wide = wide_space(fault_va, user_wide_addressing,
    supervisor_wide_addressing, kernel_wide_addressing);
  // Return address falls back to the branch for a delay slot.
  wire [63:0] ret_pc = in_delay_slot ? branch_pc : insn_pc;
  wire [63:0] gen_base = bev_r ? BASE_BEV1 : BASE_BEV0;
  wire [63:0] gen_off = (is_refill && !exl_r) ?
    (wide ? OFF_XREFILL : OFF_REFILL) : OFF_GEN;
  wire [63:0] cerr_vec = (bev_r ? BASE_BEV1 : CERR_BASE_BEV0) + OFF_CERR;

  // Customary cause encodings per rank.
  logic [4:0] code_sel;
  always_comb begin
    unique case (rank)
      RK_F_DBG: code_sel = CC_BP;
      RK_F_ADE, RK_D_ADE: code_sel = store_side ? CC_ADDR_FAULT_STORE_CODE : CC_ADDR_FAULT_LOAD_CODE;
      RK_F_REFILL, RK_F_INVAL, RK_D_REFILL, RK_D_INVAL:
        code_sel = store_side ? CC_XLAT_MISS_STORE_CODE : CC_XLAT_MISS_LOAD_CODE;
      RK_D_MOD: code_sel = CC_MOD;
      RK_F_BUS: code_sel = CC_IBE;
      RK_D_BUS: code_sel = CC_DBE;
      RK_EXEC: code_sel = exec_code;
      RK_WATCH: code_sel = CC_WATCH;
      default: code_sel = CC_INT;
    endcase
  end

  // ==========================================================
  // Next values of the status and capture registers
  wire rst_like = (ent == ENT_SOFT) || (ent == ENT_NMI);
  wire gen_ent = (ent == ENT_GEN);
  wire [63:0] vec_nxt = (ent == ENT_GEN) ? gen_base + gen_off :
    (ent == ENT_CERR) ? cerr_vec : RESET_VEC;
  wire erl_nxt = (ent == ENT_COLD || rst_like || ent == ENT_CERR) ? 1'b1 :
    sw_status_wr ? sw_error_level : erl_r;
  wire bev_nxt = (ent == ENT_COLD || rst_like) ? 1'b1 :
    sw_status_wr ? sw_boot_vector : bev_r;
  wire sr_nxt = (ent == ENT_COLD) ? 1'b0 : rst_like ? 1'b1 : sr_r;
  wire exl_nxt = gen_ent ? 1'b1 :
    sw_status_wr ? sw_exception_level : exl_r;
  // The pointer walks down to the locked count, then wraps to the top.
  wire [5:0] rnd_step = (random_r <= wired_r) ? RANDOM_TOP :
    random_r - 6'h01;
  wire [5:0] random_nxt = (ent == ENT_COLD) ? RANDOM_TOP :
    (insn_boundary && (ent == ENT_NONE)) ? rnd_step : random_r;
  wire [5:0] wired_nxt = (ent == ENT_COLD) ? WIRED_RST :
    sw_wired_wr ? sw_wired : wired_r;
  wire em_nxt = (ent == ENT_COLD) ? EM_RST :
    sw_mode_enable_wr ? sw_mode_enable : em_r;
  // Set wins: a new NMI in the take cycle stays pending.
  wire nmi_pend_nxt = nmi_set || (nmi_pend_r && (ent != ENT_NMI));

  // ==========================================================
  // Pin history and status bits
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      por_low_r <= 1'b0;
      srst_low_r <= 1'b0;
      nmi_prev_r <= 1'b1;
      nmi_pend_r <= 1'b0;
      erl_r <= 1'b1;
      bev_r <= 1'b1;
      sr_r <= 1'b0;
      ts_r <= 1'b0;
      exl_r <= 1'b0;
      em_r <= EM_RST;
      random_r <= RANDOM_TOP;
      wired_r <= WIRED_RST;
      cbreset_r <= 1'b0;
    end else begin
      por_low_r <= !power_on_reset_n;
      srst_low_r <= !soft_reset_n;
      nmi_prev_r <= nmi_n;
      nmi_pend_r <= nmi_pend_nxt;
      erl_r <= erl_nxt;
      bev_r <= bev_nxt;
      sr_r <= sr_nxt;
      ts_r <= (ent == ENT_COLD) ? 1'b0 : ts_r;
      exl_r <= exl_nxt;
      em_r <= em_nxt;
      random_r <= random_nxt;
      wired_r <= wired_nxt;
      cbreset_r <= !soft_reset_n;
    end
  end

  // Entry strobe, vector and capture registers; hardwired fields follow
  // their straps every cycle, one cycle late, and read zero while reset is held.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      taken_r <= 1'b0;
      vec_r <= RESET_VEC;
      code_r <= CC_INT;
      bd_r <= 1'b0;
      epc_r <= '0;
      err_epc_r <= '0;
      badv_r <= '0;
      ehi_r <= '0;
      xctx_r <= '0;
      ec_r <= 3'h0;
      endian_r <= 1'b0;
    end else begin
      taken_r <= (ent != ENT_NONE);
      vec_r <= (ent != ENT_NONE) ? vec_nxt : vec_r;
      code_r <= gen_ent ? code_sel : code_r;
      bd_r <= (gen_ent && !exl_r) ? in_delay_slot : bd_r;
      epc_r <= (gen_ent && !exl_r) ? ret_pc : epc_r;
      err_epc_r <= (rst_like || ent == ENT_CERR) ? ret_pc :
        err_epc_r;
      badv_r <= (gen_ent && (is_ade || is_tlb)) ? fault_va :
        badv_r;
      ehi_r <= (gen_ent && is_tlb) ?
        {fault_va[63:VPN2_LSB], 5'h00, address_space_id} : ehi_r;
      xctx_r <= (gen_ent && is_tlb) ?
        fault_va[XCTX_MSB:VPN2_LSB] : xctx_r;
      ec_r <= clock_ratio_hw;
      endian_r <= endian_hw;
    end
  end

  // ==========================================================
  // Output drive
  assign exc_taken = taken_r;
  assign exc_vector = vec_r;
  assign cache_bus_reset = cbreset_r;
  assign error_level_bit = erl_r;
  assign boot_vector_select = bev_r;
  assign soft_restart_flag = sr_r;
  assign tlb_shutdown_bit = ts_r;
  assign exception_level_bit = exl_r;
  assign mode_enable_field = em_r;
  assign clock_ratio_field = ec_r;
  assign endian_select = endian_r;
  assign processor_identity_reg = IDENT_CODE;
  assign tlb_random = random_r;
  assign tlb_wired = wired_r;
  assign cause_code_field = code_r;
  assign delay_slot_flag = bd_r;
  assign exception_return_addr = epc_r;
  assign error_return_addr = err_epc_r;
  assign faulting_vaddr_reg = badv_r;
  assign tlb_entry_high = ehi_r;
  assign wide_page_table_pointer = xctx_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence por_pulse;
    !power_on_reset_n ##1 power_on_reset_n;
  endsequence
  sequence nmi_fall;
    nmi_n ##1 !nmi_n;
  endsequence

  chk_cold_entry: assert property (por_pulse |=> exc_taken &&
    exc_vector == RESET_VEC && error_level_bit && boot_vector_select &&
    !soft_restart_flag && tlb_random == RANDOM_TOP && tlb_wired == WIRED_RST)
    else $error("cold reset entry state wrong");
  chk_soft_keep: assert property (ent == ENT_SOFT |=>
    soft_restart_flag && error_level_bit && boot_vector_select &&
    tlb_wired == $past(wired_r) && error_return_addr == $past(ret_pc))
    else $error("soft reset entry state wrong");
  chk_nmi_edge: assert property (nmi_fall |=> nmi_pend_r)
    else $error("nmi edge not latched");
  chk_nmi_unmasked: assert property (nmi_pend_r && insn_boundary
    && power_on_reset_n && soft_reset_n && !por_low_r && !srst_low_r |=>
    exc_taken && exc_vector == RESET_VEC && soft_restart_flag)
    else $error("nmi not taken at boundary");
  chk_nmi_boundary: assert property (ent == ENT_NMI |->
    insn_boundary && !cache_bus_reset) else $error("nmi taken off boundary");
  chk_prio_order: assert property (gen_ent |-> req[rank] &&
    ((req & ((15'h0001 << rank) - 15'h0001)) == 15'h0000))
    else $error("lower rank reported");
  chk_refill_vec: assert property (gen_ent && is_refill && !exl_r
    |=> exc_vector == $past(gen_base) +
    ($past(wide) ? OFF_XREFILL : OFF_REFILL))
    else $error("refill vector wrong");
  chk_epc_delay: assert property (gen_ent && !exl_r &&
    in_delay_slot |=> exception_return_addr == $past(branch_pc) &&
    delay_slot_flag && exception_level_bit)
    else $error("delay slot return wrong");
  chk_badv_capture: assert property (gen_ent && is_ade |=>
    faulting_vaddr_reg == $past(fault_va)) else $error("fault addr lost");
  chk_cbus_reset: assert property (!soft_reset_n [*2] |->
    cache_bus_reset) else $error("cache bus reset missing");
endmodule // cep_exc_unit
`default_nettype wire

// file: bench/cep_pin_model.sv
// Model of the system logic that drives the reset and interrupt pins.
`default_nettype none
module cep_pin_model (
  // Clock
  input wire logic clock,
  // Pins toward the core
  output logic power_on_reset_n,
  output logic soft_reset_n,
  output logic nmi_n,
  output logic int_reg_wr,
  output logic [7:0] int_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Pin sequences; reset and NMI pins idle high with no write pending.
  initial begin
    {power_on_reset_n, soft_reset_n, nmi_n, int_reg_wr} = 4'hE;
    int_reg_wdata = 8'hA5;
  end
  // Low for n cycles, then released; the core acts on the release of a reset and on the fall of NMI.
  task automatic pulse(input int k, input int n);
    @(negedge clock);
    if (k == 0) power_on_reset_n = 1'h0;
    if (k == 1) soft_reset_n = 1'h0;
    if (k == 2) nmi_n = 1'h0;
    repeat (n) @(negedge clock);
    {power_on_reset_n, soft_reset_n, nmi_n} = 3'h7;
  endtask
  // One-cycle register write; stale data is inverted so nothing leans on it.
  task automatic int_write(input logic [7:0] d);
    @(negedge clock);
    int_reg_wr = 1'h1;
    int_reg_wdata = d;
    @(negedge clock);
    int_reg_wr = 1'h0;
    int_reg_wdata = ~d;
  endtask
endmodule // cep_pin_model
`default_nettype wire

// file: bench/cpu_exception_priority_unit_test.sv
// Self-checking bench for the exception priority unit.
`default_nettype none
`define CK(n, e, a) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, (e), (a)); end end
module cpu_exception_priority_unit_test import cep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, power_on_reset_n, soft_reset_n, nmi_n, int_reg_wr;
  logic irq_pending, insn_boundary, in_delay_slot, f_valid, f_tlb_hit;
  logic f_tlb_valid, f_dbg_break, f_cache_err, f_bus_err, exec_req, d_valid;
  logic d_store, d_tlb_hit, d_tlb_valid, d_tlb_dirty, d_cache_err, d_bus_err;
  logic watch_hit, global_irq_enable, user_wide_addressing, sw_status_wr;
  logic supervisor_wide_addressing, kernel_wide_addressing, sw_error_level;
  logic sw_boot_vector, sw_exception_level, sw_wired_wr, sw_mode_enable_wr;
  logic sw_mode_enable, endian_hw, exc_taken, cache_bus_reset, endian_select;
  logic error_level_bit, boot_vector_select, soft_restart_flag;
  logic tlb_shutdown_bit, exception_level_bit, mode_enable_field;
  logic delay_slot_flag;
  logic [1:0] cur_mode, d_size;
  logic [2:0] clock_ratio_hw, clock_ratio_field;
  logic [4:0] exec_code, cause_code_field;
  logic [5:0] sw_wired, tlb_random, tlb_wired;
  logic [7:0] int_reg_wdata, address_space_id, processor_identity_reg;
  logic [26:0] wide_page_table_pointer;
  logic [63:0] insn_pc, branch_pc, f_vaddr, d_vaddr, exc_vector;
  logic [63:0] exception_return_addr, error_return_addr, faulting_vaddr_reg;
  logic [63:0] tlb_entry_high;
  logic [3:0] tv [4] = '{4'h0, 4'h3, 4'h8, 4'hE};
  logic [4:0] tc [4] = '{5'h02, 5'h03, 5'h02, 5'h01};
  logic [63:0] to [4] = '{64'h0, 64'h80, 64'h180, 64'h180};
  int error_cnt = 0;
  int n_checks = 0;
  int seed;
  cep_exc_unit dut_u (.*);
  cep_pin_model pm (.*);
  // ==========
  // Clock and the shared tasks.
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Waits a bounded time for the entry pulse; a hang counts as a mismatch.
  task automatic wt();
    int i;
    for (i = 0; i < 20; i++) begin
      if (exc_taken === 1'h1) break;
      @(posedge clock);
      #1;
    end
    if (i == 20) begin
      error_cnt++;
      test_done();
    end
  endtask
  // Clears the status levels, offers one boundary, checks a general entry.
  task automatic gen(input logic [4:0] c, input logic [63:0] va,
      input logic [63:0] off);
    @(negedge clock);
    sw_status_wr = 1'h1;
    @(negedge clock);
    sw_status_wr = 1'h0;
    insn_boundary = 1'h1;
    @(negedge clock);
    insn_boundary = 1'h0;
    wt();
    `CK("code", c, cause_code_field)
    `CK("vaddr", va, faulting_vaddr_reg)
    `CK("vector", 64'hFFFF_FFFF_8000_0000 + off, exc_vector)
    `CK("exl", 1'h1, exception_level_bit)
    @(negedge clock);
  endtask
  // ==========
  // Main sequence.
  initial begin
    seed = 32'h249A;
    {irq_pending, insn_boundary, in_delay_slot, f_valid, f_tlb_hit,
      f_dbg_break, f_cache_err, f_bus_err, exec_req, d_valid, d_store} = '0;
    {d_tlb_hit, d_tlb_valid, d_tlb_dirty, d_cache_err, d_bus_err, watch_hit,
      global_irq_enable, user_wide_addressing, supervisor_wide_addressing,
      kernel_wide_addressing, sw_error_level, sw_boot_vector} = '0;
    {sw_status_wr, sw_exception_level, sw_wired_wr, sw_mode_enable_wr} = '0;
    {sw_mode_enable, f_tlb_valid, cur_mode, d_size, exec_code, sw_wired} = '0;
    {insn_pc, branch_pc, f_vaddr, d_vaddr, address_space_id} = '0;
    {clock_ratio_hw, endian_hw} = 4'($random(seed));
    sys_rst = 1'h1;
    repeat (5) @(posedge clock);
    @(negedge clock) sys_rst = 1'h0;
    pm.pulse(0, 2);
    wt();
    `CK("vector", RESET_VEC, exc_vector)
    `CK("sr ts erl bev", 4'h3, {soft_restart_flag, tlb_shutdown_bit,
      error_level_bit, boot_vector_select})
    `CK("random", 6'h2F, tlb_random)
    `CK("wired", 6'h00, tlb_wired)
    `CK("mode", 1'h0, mode_enable_field)
    `CK("straps", {clock_ratio_hw, endian_hw, IDENT_CODE},
      {clock_ratio_field, endian_select, processor_identity_reg})
    $display("test cold done");
    @(negedge clock);
    {sw_wired_wr, sw_mode_enable_wr, sw_mode_enable} = 3'h7;
    sw_wired = 6'h05;
    insn_pc = {$random(seed), $random(seed)};
    @(negedge clock);
    {sw_wired_wr, sw_mode_enable_wr} = 2'h0;
    fork
      pm.pulse(1, 3);
    join_none
    repeat (2) @(negedge clock);
    `CK("cbr", 1'h1, cache_bus_reset)
    wt();
    `CK("vector", RESET_VEC, exc_vector)
    `CK("sr erl bev", 3'h7, {soft_restart_flag, error_level_bit,
      boot_vector_select})
    `CK("kept", {6'h2F, 6'h05, 1'h1},
      {tlb_random, tlb_wired, mode_enable_field})
    `CK("errpc", insn_pc, error_return_addr)
    $display("test soft done");
    @(negedge clock);
    {sw_status_wr, sw_exception_level} = 2'h3;
    @(negedge clock);
    {sw_status_wr, sw_exception_level} = 2'h0;
    pm.pulse(2, 1);
    repeat (4) begin
      @(negedge clock);
      `CK("early", 1'h0, exc_taken)
    end
    insn_boundary = 1'h1;
    @(negedge clock);
    insn_boundary = 1'h0;
    wt();
    `CK("nmi", {RESET_VEC, 4'hF}, {exc_vector, soft_restart_flag,
      error_level_bit, boot_vector_select, exception_level_bit})
    `CK("cbr", 1'h0, cache_bus_reset)
    `CK("errpc", insn_pc, error_return_addr)
    insn_boundary = 1'h1;
    pm.int_write(8'h40);
    wt();
    `CK("nmi bit", 1'h1, soft_restart_flag)
    $display("test nmi done");
    @(negedge clock);
    insn_boundary = 1'h0;
    d_valid = 1'h1;
    for (int k = 0; k < 8; k++) begin
      d_store = 1'($random(seed));
      in_delay_slot = 1'($random(seed));
      insn_pc = {$random(seed), $random(seed)};
      branch_pc = {$random(seed), $random(seed)};
      d_size = 2'h1 + 2'(k % 3);
      d_vaddr = {32'hFFFF_FFFF, 2'h2, 27'($random(seed)),
        3'($random(seed)) | 3'h1};
      gen(d_store ? 5'h05 : 5'h04, d_vaddr, 64'h180);
      `CK("epc", in_delay_slot ? branch_pc : insn_pc,
        exception_return_addr)
      `CK("bd", in_delay_slot, delay_slot_flag)
    end
    {d_store, d_vaddr[2:0], cur_mode} = 6'h02;
    gen(5'h04, d_vaddr, 64'h180);
    $display("test address done");
    {cur_mode, in_delay_slot} = 3'h0;
    d_vaddr = 64'h0000_0000_0012_3000;
    address_space_id = 8'($random(seed));
    for (int k = 0; k < 4; k++) begin
      {d_tlb_hit, d_tlb_valid, d_store, user_wide_addressing} = tv[k];
      gen(tc[k], d_vaddr, to[k]);
      `CK("hi", {d_vaddr[63:13], 5'h00, address_space_id},
        tlb_entry_high)
      `CK("ctx", d_vaddr[39:13], wide_page_table_pointer)
    end
    $display("test tlb done");
    {f_valid, f_dbg_break, f_bus_err, exec_req, d_store, watch_hit} = 6'h3F;
    {d_bus_err, d_tlb_hit, d_tlb_valid, d_tlb_dirty} = 4'hF;
    {d_size, exec_code} = {2'h2, 5'h0C};
    f_vaddr = 64'hFFFF_FFFF_8000_0002;
    gen(5'h09, d_vaddr, 64'h180);
    f_dbg_break = 1'h0;
    gen(5'h04, f_vaddr, 64'h180);
    f_valid = 1'h0;
    gen(5'h0C, f_vaddr, 64'h180);
    exec_req = 1'h0;
    d_vaddr = 64'hFFFF_FFFF_8000_0011;
    gen(5'h05, d_vaddr, 64'h180);
    d_valid = 1'h0;
    gen(5'h17, d_vaddr, 64'h180);
    {watch_hit, irq_pending, global_irq_enable} = 3'h3;
    gen(5'h00, d_vaddr, 64'h180);
    $display("test priority done");
    test_done();
  end
endmodule // cpu_exception_priority_unit_test
`default_nettype wire
